//--- core/tmr_pkg.sv
// Shared constants for the 16-bit timer/event counter.
// Assumes a single core clock and a plain register port with 4-bit word addresses.
package tmr_pkg;

   // Register word addresses
   localparam logic [3:0]  OFS_MODE      = 4'h0;
   localparam logic [3:0]  OFS_CCC       = 4'h1;
   localparam logic [3:0]  OFS_PRESC     = 4'h2;
   localparam logic [3:0]  OFS_OUTC      = 4'h3;
   localparam logic [3:0]  OFS_CMPA      = 4'h4;
   localparam logic [3:0]  OFS_CMPB      = 4'h5;
   localparam logic [3:0]  OFS_CNT       = 4'h6;

   // Field positions
   localparam int          POS_OVF       = 0;
   localparam int          POS_OPM_LO    = 2;
   localparam int          POS_FSEL      = 0;
   localparam int          POS_CSEL_LO   = 0;
   localparam int          POS_EDGE_LO   = 4;
   localparam int          POS_OE        = 0;
   localparam int          POS_TOG_A     = 1;
   localparam int          POS_TOG_B     = 4;
   localparam int          POS_OS_EN     = 5;
   localparam int          POS_OS_TRIG   = 6;

   // Reset values and counter maximum
   localparam logic [7:0]  RST_CTRL      = 8'h00;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [15:0] CNT_MAX       = 16'hFFFF;

   // Operating modes
   typedef enum logic [1:0] {
      OPM_STOP      = 2'h0,
      OPM_EDGE_CLR  = 2'h1,
      OPM_FREE      = 2'h2,
      OPM_MATCH_CLR = 2'h3
   } opm_t;

   // Edge select codes
   localparam logic [1:0]  EDGE_FALL     = 2'h0;
   localparam logic [1:0]  EDGE_RISE     = 2'h1;
   localparam logic [1:0]  EDGE_NONE     = 2'h2;
   localparam logic [1:0]  EDGE_BOTH     = 2'h3;

   // Count clock selection
   localparam logic [1:0]  CSEL_DIV1     = 2'h0;
   localparam logic [1:0]  CSEL_DIV2     = 2'h1;
   localparam logic [1:0]  CSEL_DIV4     = 2'h2;
   localparam logic [1:0]  CSEL_PIN      = 2'h3;

   // One-shot states
   typedef enum logic [2:0] {
      OS_IDLE   = 3'b001,
      OS_WAIT   = 3'b010,
      OS_ACTIVE = 3'b100
   } os_state_t;

endpackage

//--- core/tmr_filt_if.sv
// Carries the raw timer input and its filtered level.
// Assumes both ends run on the core clock.
interface tmr_filt_if;
   logic raw;
   logic level;
   modport filt (input raw, output level);
   modport user (output raw, input level);
endinterface

//--- core/tmr_pin_filter.sv
// Level filter for the timer input pin.
// Assumes the pin is already synchronous to the core clock.
module tmr_pin_filter (
   input  wire logic  i_core_clk,
   input  wire logic  i_rst_n,
   tmr_filt_if.filt   fif
);

   logic [1:0] samp_ff;
   logic       level_ff;

   // Two consecutive samples
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         samp_ff <= 2'h0;
      end else begin
         samp_ff <= {samp_ff[0], fif.raw};
      end
   end

   // New level taken only when both samples agree
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         level_ff <= 1'b0;
      end else if (samp_ff[0] == samp_ff[1]) begin
         level_ff <= samp_ff[0]; // R6
      end
   end

   assign fif.level = level_ff;

   chk_filter_two_samples: assert property ( // R6
      @(posedge i_core_clk) disable iff (!i_rst_n)
      $changed(level_ff) |-> (level_ff == $past(fif.raw, 2)) && (level_ff == $past(fif.raw, 3)))
      else $error("filtered level changed without two equal samples");

endmodule

//--- core/timer16_event_square_oneshot.sv
// 16-bit timer with event counting, square-wave and one-shot pulse output.
// Assumes a synchronous timer input pin and a one-cycle register port.

// Functional notes
// R1: Software programs compare control, prescaler, nonzero compare A, then mode.
// R2: Event mode counts one per valid filtered input edge.
// R3: Counter equal to compare A clears counter and pulses match A.
// R4: Software keeps compare A nonzero in event mode.
// R5: Prescaler bits 5:4 pick falling, rising or both edges.
// R6: Input edge accepted only after two equal samples of new level.
// R7: Overflow flag sets only when counter wraps past maximum.
// R8: Function select bit 0 clear makes compare A a compare register.
// R9: Software reads event count from the counter itself.
// R10: Software sets prescaler, compare control, output control, compares, then mode.
// R11: Enable and toggle-A bits invert output every compare A plus one.
// R12: Software leaves compare A alone while square wave runs.
// R13: Soft trigger bit 6 restarts counter; with B below A, active at B, inactive at A.
// R14: With B above A, active at A match, inactive at B match.
// R15: Counter keeps running after pulse; stops only on mode 00.
// R16: Counter runs at once when mode bits are nonzero.
// R17: Software does not trigger again while a pulse is out.
// R18: In soft-trigger one-shot, a valid input edge still restarts counter; the code restarts on edges only in edge-clear mode 01.
// R19: External valid edge clears and starts counter and one-shot pulse.
// R20: Software loads both compares nonzero before one-shot use.
// R21: External edge during a pulse is ignored.
// R22: Output held inactive when output disabled or counter stopped.
module timer16_event_square_oneshot (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic        i_timer_input_pin,
   output logic             o_timer_output_pin,
   output logic             o_match_a_interrupt,
   output logic             o_match_b_interrupt
);

   logic [7:0]          mode_control_reg_ff;
   logic [7:0]          capture_compare_control_ff;
   logic [7:0]          prescaler_mode_reg_ff;
   logic [7:0]          output_control_reg_ff;
   logic [15:0]         compare_reg_a_ff;
   logic [15:0]         compare_reg_b_ff;
   logic [15:0]         main_counter_ff;
   logic [15:0]         nxt_main_counter;
   logic [15:0]         rdata_ff;
   logic [1:0]          div_ff;
   logic                prev_level_ff;
   logic                out_ff;
   logic                nxt_out;
   logic                irq_a_ff;
   logic                irq_b_ff;
   tmr_pkg::os_state_t  os_state_ff;
   tmr_pkg::os_state_t  nxt_os_state;
   tmr_pkg::opm_t       opm;
   logic [1:0]          edge_sel;
   logic [1:0]          csel;
   logic                running;
   logic                level;
   logic                valid_edge;
   logic                div_tick;
   logic                tick;
   logic                os_en;
   logic                os_busy;
   logic                soft_trig;
   logic                ext_restart;
   logic                restart;
   logic                match_a;
   logic                match_b;
   logic                first_evt;
   logic                second_evt;
   logic                ovf_evt;
   logic                wr_mode;

   tmr_filt_if fif ();

   // Input pin filter
   assign fif.raw = i_timer_input_pin;
   assign level   = fif.level;

   tmr_pin_filter u_filter (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .fif        (fif)
   );

   // Picks whether a level change is a valid edge
   function automatic logic edge_ok(input logic [1:0] sel, input logic rise,
                                    input logic fall);
      unique case (sel)
         tmr_pkg::EDGE_FALL: edge_ok = fall;
         tmr_pkg::EDGE_RISE: edge_ok = rise;
         tmr_pkg::EDGE_BOTH: edge_ok = rise | fall;
         default:            edge_ok = 1'b0;
      endcase
   endfunction

   // Field decode
   assign opm      = tmr_pkg::opm_t'(mode_control_reg_ff[tmr_pkg::POS_OPM_LO +: 2]);
   assign edge_sel = prescaler_mode_reg_ff[tmr_pkg::POS_EDGE_LO +: 2];
   assign csel     = prescaler_mode_reg_ff[tmr_pkg::POS_CSEL_LO +: 2];
   assign os_en    = output_control_reg_ff[tmr_pkg::POS_OS_EN];
   assign running  = (opm != tmr_pkg::OPM_STOP); // R16
   assign os_busy  = (os_state_ff != tmr_pkg::OS_IDLE);
   assign wr_mode  = i_wr && (i_addr == tmr_pkg::OFS_MODE);

   // Valid edge detection, ignored while stopped
   assign valid_edge = running && edge_ok(edge_sel, level & ~prev_level_ff,
                                          ~level & prev_level_ff); // R5

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         prev_level_ff <= 1'b0;
      end else begin
         prev_level_ff <= level;
      end
   end

   // Prescaler divider
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end

   always_comb begin
      unique case (csel)
         tmr_pkg::CSEL_DIV1: div_tick = 1'b1;
         tmr_pkg::CSEL_DIV2: div_tick = div_ff[0];
         tmr_pkg::CSEL_DIV4: div_tick = (div_ff == 2'h3);
         default:            div_tick = 1'b0;
      endcase
   end

   // Count clock: input edges or divided system clock
   assign tick = running && ((csel == tmr_pkg::CSEL_PIN) ? valid_edge : div_tick); // R2

   // Restart sources
   assign soft_trig   = running && os_en && i_wr && (i_addr == tmr_pkg::OFS_OUTC)
                        && i_wdata[tmr_pkg::POS_OS_TRIG]; // R13
   assign ext_restart = (opm == tmr_pkg::OPM_EDGE_CLR) && (csel != tmr_pkg::CSEL_PIN)
                        && valid_edge && !(os_en && os_busy); // R18 R19 R21
   assign restart     = soft_trig || ext_restart;

   // Compare matches; A is compare only while function select is clear
   assign match_a = tick && !restart && (main_counter_ff == compare_reg_a_ff)
                    && !capture_compare_control_ff[tmr_pkg::POS_FSEL]; // R8
   assign match_b = tick && !restart && (main_counter_ff == compare_reg_b_ff);
   assign ovf_evt = tick && !restart && (main_counter_ff == tmr_pkg::CNT_MAX); // R7

   // Main counter
   always_comb begin
      nxt_main_counter = main_counter_ff;
      if (!running) begin
         nxt_main_counter = tmr_pkg::RST_WORD; // R15
      end else if (restart) begin
         nxt_main_counter = tmr_pkg::RST_WORD; // R13
      end else if (tick) begin
         if (match_a && (opm == tmr_pkg::OPM_MATCH_CLR)) begin
            nxt_main_counter = tmr_pkg::RST_WORD; // R3
         end else begin
            nxt_main_counter = main_counter_ff + 16'h0001; // R2
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         main_counter_ff <= tmr_pkg::RST_WORD;
      end else begin
         main_counter_ff <= nxt_main_counter;
      end
   end

   // Mode register; overflow set wins over a software clear
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         mode_control_reg_ff <= tmr_pkg::RST_CTRL;
      end else begin
         mode_control_reg_ff <= wr_mode ? i_wdata[7:0] : mode_control_reg_ff;
         if (ovf_evt) begin
            mode_control_reg_ff[tmr_pkg::POS_OVF] <= 1'b1; // R7
         end
      end
   end

   // Control registers; the trigger bit is never stored
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         capture_compare_control_ff <= tmr_pkg::RST_CTRL;
         prescaler_mode_reg_ff      <= tmr_pkg::RST_CTRL;
         output_control_reg_ff      <= tmr_pkg::RST_CTRL;
      end else if (i_wr) begin
         if (i_addr == tmr_pkg::OFS_CCC) begin
            capture_compare_control_ff <= i_wdata[7:0];
         end
         if (i_addr == tmr_pkg::OFS_PRESC) begin
            prescaler_mode_reg_ff <= i_wdata[7:0];
         end
         if (i_addr == tmr_pkg::OFS_OUTC) begin
            output_control_reg_ff <= i_wdata[7:0] & ~(8'h01 << tmr_pkg::POS_OS_TRIG);
         end
      end
   end

   // Compare registers
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         compare_reg_a_ff <= tmr_pkg::RST_WORD;
         compare_reg_b_ff <= tmr_pkg::RST_WORD;
      end else if (i_wr) begin
         if (i_addr == tmr_pkg::OFS_CMPA) begin
            compare_reg_a_ff <= i_wdata;
         end
         if (i_addr == tmr_pkg::OFS_CMPB) begin
            compare_reg_b_ff <= i_wdata;
         end
      end
   end

   // One-shot ordering: B first when B below A, else A first
   assign first_evt  = (compare_reg_b_ff < compare_reg_a_ff) ? match_b : match_a; // R14
   assign second_evt = (compare_reg_b_ff < compare_reg_a_ff) ? match_a : match_b; // R14

   always_comb begin
      nxt_os_state = os_state_ff;
      if (!running || !os_en) begin
         nxt_os_state = tmr_pkg::OS_IDLE;
      end else begin
         unique case (os_state_ff)
            tmr_pkg::OS_IDLE: begin
               if (restart) begin
                  nxt_os_state = tmr_pkg::OS_WAIT; // R19
               end
            end
            tmr_pkg::OS_WAIT: begin
               if (first_evt) begin
                  nxt_os_state = tmr_pkg::OS_ACTIVE; // R13
               end
            end
            tmr_pkg::OS_ACTIVE: begin
               if (second_evt) begin
                  nxt_os_state = tmr_pkg::OS_IDLE; // R13
               end
            end
            default: nxt_os_state = tmr_pkg::OS_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         os_state_ff <= tmr_pkg::OS_IDLE;
      end else begin
         os_state_ff <= nxt_os_state;
      end
   end

   // Output pin level
   always_comb begin
      if (!running || !output_control_reg_ff[tmr_pkg::POS_OE]) begin
         nxt_out = 1'b0; // R22
      end else if (os_en) begin
         nxt_out = (nxt_os_state == tmr_pkg::OS_ACTIVE);
      end else begin
         nxt_out = out_ff ^ ((match_a && output_control_reg_ff[tmr_pkg::POS_TOG_A])
                          || (match_b && output_control_reg_ff[tmr_pkg::POS_TOG_B])); // R11
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         out_ff <= 1'b0;
      end else begin
         out_ff <= nxt_out;
      end
   end

   // Match interrupt pulses
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         irq_a_ff <= 1'b0;
         irq_b_ff <= 1'b0;
      end else begin
         irq_a_ff <= match_a; // R3
         irq_b_ff <= match_b;
      end
   end

   // Read data, valid only the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= tmr_pkg::RST_WORD;
      end else if (!i_rd) begin
         rdata_ff <= tmr_pkg::RST_WORD;
      end else begin
         unique case (i_addr)
            tmr_pkg::OFS_MODE:  rdata_ff <= {8'h00, mode_control_reg_ff};
            tmr_pkg::OFS_CCC:   rdata_ff <= {8'h00, capture_compare_control_ff};
            tmr_pkg::OFS_PRESC: rdata_ff <= {8'h00, prescaler_mode_reg_ff};
            tmr_pkg::OFS_OUTC:  rdata_ff <= {8'h00, output_control_reg_ff};
            tmr_pkg::OFS_CMPA:  rdata_ff <= compare_reg_a_ff;
            tmr_pkg::OFS_CMPB:  rdata_ff <= compare_reg_b_ff;
            tmr_pkg::OFS_CNT:   rdata_ff <= main_counter_ff;
            default:            rdata_ff <= tmr_pkg::RST_WORD;
         endcase
      end
   end

   assign o_rdata             = rdata_ff;
   assign o_timer_output_pin  = out_ff;
   assign o_match_a_interrupt = irq_a_ff;
   assign o_match_b_interrupt = irq_b_ff;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   chk_event_count_step: assert property ( // R2
      (opm == tmr_pkg::OPM_MATCH_CLR) && (csel == tmr_pkg::CSEL_PIN) && valid_edge
      && (main_counter_ff != compare_reg_a_ff) && !wr_mode
      |=> main_counter_ff == $past(main_counter_ff) + 16'h0001)
      else $error("event edge did not advance counter");

   chk_match_a_clear: assert property ( // R3
      (opm == tmr_pkg::OPM_MATCH_CLR) && match_a && !wr_mode
      |=> (main_counter_ff == 16'h0000) && o_match_a_interrupt)
      else $error("match A did not clear counter and interrupt");

   chk_edge_select: assert property ( // R5
      valid_edge |-> ((edge_sel == tmr_pkg::EDGE_RISE) && level)
                  || ((edge_sel == tmr_pkg::EDGE_FALL) && !level)
                  || ((edge_sel == tmr_pkg::EDGE_BOTH) && (level != prev_level_ff)))
      else $error("edge accepted against edge select");

   chk_overflow_max: assert property ( // R7
      $rose(mode_control_reg_ff[tmr_pkg::POS_OVF]) && !$past(wr_mode)
      |-> $past(main_counter_ff) == tmr_pkg::CNT_MAX)
      else $error("overflow flag set without wrap");

   chk_capture_no_match: assert property ( // R8
      capture_compare_control_ff[tmr_pkg::POS_FSEL] |=> !o_match_a_interrupt)
      else $error("match A raised while in capture selection");

   chk_square_toggle: assert property ( // R11
      running && !os_en && output_control_reg_ff[tmr_pkg::POS_OE]
      && output_control_reg_ff[tmr_pkg::POS_TOG_A] && !output_control_reg_ff[tmr_pkg::POS_TOG_B]
      && !$past(match_a) ##1 match_a && !i_wr |=> o_timer_output_pin != $past(o_timer_output_pin))
      else $error("output did not invert on match A");

   chk_soft_restart: assert property ( // R13
      soft_trig && !wr_mode |=> (main_counter_ff == 16'h0000) && os_busy)
      else $error("soft trigger did not restart counter");

   chk_stop_clear: assert property ( // R15
      !running |=> main_counter_ff == 16'h0000 ##0 !os_busy)
      else $error("counter not halted in stop mode");

   chk_ext_ignored: assert property ( // R21
      os_en && os_busy && !soft_trig && running && !match_a && !match_b && !wr_mode
      |=> main_counter_ff == $past(main_counter_ff) + {15'h0000, $past(tick)})
      else $error("edge restarted counter during pulse");

   chk_output_idle: assert property ( // R22
      (!running || !output_control_reg_ff[tmr_pkg::POS_OE]) |=> !o_timer_output_pin)
      else $error("output active while disabled or stopped");

endmodule

//--- verification/tmr_pin_partner.sv
// Pulse source standing in for the circuit that drives the timer input pin.
// Assumes one-cycle fire requests on the core clock; widths are in core cycles.
module tmr_pin_partner (
   input  wire logic       i_core_clk,
   input  wire logic       i_fire,
   input  wire logic [3:0] i_high,
   input  wire logic [3:0] i_low,
   input  wire logic [3:0] i_count,
   output logic            o_busy,
   output logic            o_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // Burst of pulses; pin rests low and steady between bursts
   initial begin
      o_pin = 1'h0;
      o_busy = 1'h0;
      forever begin
         @(posedge i_core_clk);
         if (i_fire === 1'h1) begin
            o_busy <= 1'h1;
            for (int p = 0; p < int'(i_count); p++) begin
               o_pin <= 1'h1;
               repeat (i_high) @(posedge i_core_clk);
               o_pin <= 1'h0;
               repeat (i_low) @(posedge i_core_clk);
            end
            o_busy <= 1'h0;
         end
      end
   end
endmodule

//--- verification/timer16_event_square_oneshot_bench.sv
// Self-checking bench: registers, event counting, square wave, one-shot output.
// Assumes the pin partner drives the timer input and the register port never stalls.
module timer16_event_square_oneshot_bench;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct {
      logic [15:0] ccc;
      logic [1:0]  edge_sel;
      logic [15:0] cmp_a;
      logic [3:0]  high;
      logic [3:0]  pulses;
      logic [15:0] count;
      logic [15:0] irqs;
   } ev_row_t;

   // Event rows: control, edge, compare A, pulse width, pulses -> count, match A pulses
   ev_row_t rows [7] = '{
      '{16'h0000, 2'h1, 16'hFFFF, 4'h3, 4'h3, 16'h0003, 16'h0000},
      '{16'h0000, 2'h0, 16'hFFFF, 4'h3, 4'h3, 16'h0003, 16'h0000},
      '{16'h0000, 2'h3, 16'hFFFF, 4'h3, 4'h3, 16'h0006, 16'h0000},
      '{16'h0000, 2'h2, 16'hFFFF, 4'h3, 4'h3, 16'h0000, 16'h0000},
      '{16'h0000, 2'h1, 16'h0003, 4'h3, 4'h5, 16'h0001, 16'h0001},
      '{16'h0000, 2'h1, 16'hFFFF, 4'h1, 4'h2, 16'h0000, 16'h0000},
      '{16'h0001, 2'h1, 16'h0003, 4'h3, 4'h5, 16'h0005, 16'h0000}
   };

   logic        clk     = 1'h0;
   logic        rst_n   = 1'h0;
   logic [3:0]  addr    = 4'h0;
   logic [15:0] wdata   = 16'h0000;
   logic        wr_s    = 1'h0;
   logic        rd_s    = 1'h0;
   logic [15:0] rdata;
   logic        pin;
   logic        out_pin;
   logic        irq_a;
   logic        irq_b;
   logic        fire    = 1'h0;
   logic [3:0]  hi      = 4'h0;
   logic [3:0]  lo      = 4'h0;
   logic [3:0]  num     = 4'h0;
   logic        busy;
   logic [15:0] v;
   logic [15:0] w;
   logic [15:0] nb;
   logic [15:0] ma;
   int          t1;
   int          t2;
   int          n0;
   int          na      = 0;
   int          nbc     = 0;
   int          cyc     = 0;
   int          bad_count = 0;
   int          tests_run = 0;

   timer16_event_square_oneshot uut (
      .i_core_clk          (clk),
      .i_rst_n             (rst_n),
      .i_addr              (addr),
      .i_wdata             (wdata),
      .i_wr                (wr_s),
      .i_rd                (rd_s),
      .o_rdata             (rdata),
      .i_timer_input_pin   (pin),
      .o_timer_output_pin  (out_pin),
      .o_match_a_interrupt (irq_a),
      .o_match_b_interrupt (irq_b)
   );

   tmr_pin_partner src (
      .i_core_clk (clk),
      .i_fire     (fire),
      .i_high     (hi),
      .i_low      (lo),
      .i_count    (num),
      .o_busy     (busy),
      .o_pin      (pin)
   );

   // 100 ns core clock
   initial begin
      forever #50 clk = ~clk;
   end

   // Cycle count and match pulse tallies
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq_a === 1'h1) na <= na + 1;
      if (irq_b === 1'h1) nbc <= nbc + 1;
   end

   task automatic end_of_test();
      $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe, then one idle cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'h1;
      @(posedge clk);
      wr_s <= 1'h0;
      @(posedge clk);
   endtask

   // Read data is taken in the cycle after the strobe only
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clk);
      rd_s <= 1'h0;
      @(posedge clk);
      d = rdata;
   endtask

   // Program in a stopped state, then start
   task automatic setup(input logic cf, input logic [15:0] pr, cc, oc, ca, cb, md);
      wr(tmr_pkg::OFS_MODE, 16'h0000);
      if (cf) wr(tmr_pkg::OFS_CCC, cc);
      wr(tmr_pkg::OFS_PRESC, pr);
      if (!cf) wr(tmr_pkg::OFS_CCC, cc);
      wr(tmr_pkg::OFS_OUTC, oc);
      wr(tmr_pkg::OFS_CMPA, ca);
      wr(tmr_pkg::OFS_CMPB, cb);
      wr(tmr_pkg::OFS_MODE, md);
   endtask

   // Ask the partner for a burst and wait until it is done
   task automatic send(input logic [3:0] h, input logic [3:0] l, input logic [3:0] n);
      int k;
      hi <= h;
      lo <= l;
      num <= n;
      fire <= 1'h1;
      @(posedge clk);
      fire <= 1'h0;
      @(posedge clk);
      for (k = 0; k < 100 && busy !== 1'h0; k++) @(posedge clk);
      if (k >= 100) begin
         check("partner burst", 16'h0000, 16'h0001);
         end_of_test();
      end
   endtask

   task automatic wait_out(input logic lvl, output int t);
      int n;
      n = 0;
      while (out_pin !== lvl && n < 300) begin
         @(posedge clk);
         n++;
      end
      if (n >= 300) begin
         check("output wait", 16'h0000, 16'h0001);
         end_of_test();
      end
      t = cyc;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'h1;
      // Reset values, read-only counter, unmapped place
      for (int a = 0; a < 8; a++) begin
         rd(4'(a), v);
         check("reset value", v, 16'h0000);
      end
      wr(tmr_pkg::OFS_PRESC, 16'hFF33);
      rd(tmr_pkg::OFS_PRESC, v);
      check("prescaler bits", v, 16'h0033);
      @(posedge clk);
      check("read data idle", rdata, 16'h0000);
      wr(tmr_pkg::OFS_CNT, 16'h1234);
      rd(tmr_pkg::OFS_CNT, v);
      check("counter read only", v, 16'h0000);
      wr(4'h9, 16'hFFFF);
      rd(4'h9, v);
      check("unmapped read", v, 16'h0000);
      // Event counting table
      foreach (rows[i]) begin
         setup(1'h1, {10'h000, rows[i].edge_sel, 4'h3}, rows[i].ccc, 16'h0000,
               rows[i].cmp_a, 16'h0000, 16'h000C);
         n0 = na;
         send(rows[i].high, 4'h3, rows[i].pulses);
         repeat (5) @(posedge clk);
         rd(tmr_pkg::OFS_CNT, v);
         check("event count", v, rows[i].count);
         check("match a pulses", 16'(na - n0), rows[i].irqs);
         rd(tmr_pkg::OFS_MODE, v);
         check("no overflow", v, 16'h000C);
      end
      // Overflow set with compare A at the top, then software clear
      setup(1'h1, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h000C);
      repeat (65540) @(posedge clk);
      rd(tmr_pkg::OFS_MODE, v);
      check("overflow set", v, 16'h000D);
      wr(tmr_pkg::OFS_MODE, 16'h000C);
      rd(tmr_pkg::OFS_MODE, v);
      check("overflow cleared", v, 16'h000C);
      // Square wave on the halved clock, then output disable and stop
      setup(1'h0, 16'h0001, 16'h0000, 16'h0003, 16'h0004, 16'h0000, 16'h000C);
      wait_out(1'h1, t1);
      wait_out(1'h0, t2);
      check("square half period", 16'(t2 - t1), 16'h000A);
      wait_out(1'h1, t1);
      wr(tmr_pkg::OFS_OUTC, 16'h0002);
      repeat (2) @(posedge clk);
      check("output disabled", 16'(out_pin), 16'h0000);
      wr(tmr_pkg::OFS_OUTC, 16'h0003);
      wait_out(1'h1, t1);
      wr(tmr_pkg::OFS_MODE, 16'h0000);
      repeat (2) @(posedge clk);
      check("output stopped", 16'(out_pin), 16'h0000);
      // Soft one-shot, compare B below and above compare A
      for (int j = 0; j < 2; j++) begin
         nb = (j == 0) ? 16'h0008 : 16'h000D;
         ma = (j == 0) ? 16'h000D : 16'h0008;
         setup(1'h0, 16'h0000, 16'h0000, 16'h0021, ma, nb, 16'h0008);
         rd(tmr_pkg::OFS_CNT, v);
         check("running at start", 16'(v != 16'h0000), 16'h0001);
         n0 = nbc;
         wr(tmr_pkg::OFS_OUTC, 16'h0061);
         wait_out(1'h1, t1);
         wait_out(1'h0, t2);
         check("soft pulse width", 16'(t2 - t1), 16'h0005);
         rd(tmr_pkg::OFS_CNT, v);
         rd(tmr_pkg::OFS_CNT, w);
         check("match b pulses", 16'(nbc - n0), 16'h0001);
         check("count keeps running", w - v, 16'h0002);
      end
      // Pin-triggered one-shot, one edge then two, the second landing inside the pulse
      for (int j = 1; j < 3; j++) begin
         setup(1'h0, 16'h0010, 16'h0000, 16'h0021, 16'h000E, 16'h0002, 16'h0004);
         fork
            send(4'h3, 4'h3, 4'(j));
            begin
               wait_out(1'h1, t1);
               wait_out(1'h0, t2);
            end
         join
         check("pin pulse width", 16'(t2 - t1), 16'h000C);
      end
      // Quarter-clock square wave, then reset in mid-run
      setup(1'h0, 16'h0002, 16'h0000, 16'h0003, 16'h0004, 16'h0000, 16'h000C);
      wait_out(1'h1, t1);
      wait_out(1'h0, t2);
      check("quarter half period", 16'(t2 - t1), 16'h0014);
      wait_out(1'h1, t1);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      check("output in reset", 16'(out_pin), 16'h0000);
      rst_n <= 1'h1;
      rd(tmr_pkg::OFS_MODE, v);
      check("mode after reset", v, 16'h0000);
      rd(tmr_pkg::OFS_CMPA, v);
      check("compare a after reset", v, 16'h0000);
      end_of_test();
   end
endmodule
